//--- src/cmb_block.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module cmb_block
    import cmb_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata_q,
    // routing matrix side
    input  wire logic [NUM_ROUTE-1:0] route_in,
    output logic      [NUM_MC-1:0]    route_fb_q,
    output logic      [NUM_HOLD-1:0]  pin_level_q,
    // global clock pins
    input  wire logic [NUM_GCLK-1:0]  gclk_pin,
    // i/o pins
    input  wire logic [NUM_IO-1:0]    io_in,
    input  wire logic [NUM_IO-1:0]    io_ext_drv,
    output logic      [NUM_IO-1:0]    io_out,
    output logic      [NUM_IO-1:0]    io_oe_q,
    // dedicated input pins
    input  wire logic [NUM_DED-1:0]   ded_in,
    input  wire logic [NUM_DED-1:0]   ded_ext_drv
);

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [NUM_GCLK-1:0] gclk_s1_q;
    logic [NUM_GCLK-1:0] gclk_s2_q;
    logic [NUM_GCLK-1:0] gclk_s3_q;
    logic [NUM_HOLD-1:0] pin_s1_q;
    logic [NUM_HOLD-1:0] pin_s2_q;
    logic [NUM_HOLD-1:0] drv_s1_q;
    logic [NUM_HOLD-1:0] drv_s2_q;
    logic [NUM_GCLK-1:0] gclk_rise;

    // pins are asynchronous to clk_sys, two flops before use
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gclk_s1_q <= '0;
            gclk_s2_q <= '0;
            gclk_s3_q <= '0;
            pin_s1_q  <= '0;
            pin_s2_q  <= '0;
            drv_s1_q  <= '0;
            drv_s2_q  <= '0;
        end else begin
            gclk_s1_q <= gclk_pin;
            gclk_s2_q <= gclk_s1_q;
            gclk_s3_q <= gclk_s2_q;
            pin_s1_q  <= {ded_in, io_in};
            pin_s2_q  <= pin_s1_q;
            drv_s1_q  <= {ded_ext_drv, io_ext_drv};
            drv_s2_q  <= drv_s1_q;
        end
    end

    // global clocks become enable pulses on their rising edge
    assign gclk_rise = gclk_s2_q & ~gclk_s3_q;

    // ***************************************************
    // register decode
    // ***************************************************
    logic                 prog_q;
    logic                 ctrl_hit;
    logic                 status_hit;
    logic                 cfg_hit;
    logic                 steer_hit;
    logic                 and_hit;
    logic [3:0]           sel_mc;
    logic [1:0]           sel_word;
    logic [TERM_IDX_W-1:0] sel_term;
    logic                 cfg_wr_ok;

    assign ctrl_hit   = (reg_addr == CTRL_ADDR);
    assign status_hit = (reg_addr == STATUS_ADDR);
    assign cfg_hit    = (reg_addr[11:6] == CFG_PAGE);
    assign steer_hit  = (reg_addr[11:8] == STEER_PAGE);
    assign sel_term   = reg_addr[10:4];
    assign sel_word   = reg_addr[3:2];
    assign and_hit    = (reg_addr[11:11] == AND_PAGE) && (int'(sel_term) < NUM_TERM)
                        && (int'(sel_word) < AND_WORDS);
    assign sel_mc     = cfg_hit ? reg_addr[5:2] : reg_addr[7:4];
    assign cfg_wr_ok  = reg_wr && prog_q;

    // ***************************************************
    // configuration store
    // ***************************************************
    logic [AND_ROW_W-1:0]   and_mask_q [NUM_TERM];
    logic [STEER_ROW_W-1:0] steer_q    [NUM_MC];
    cmb_cfg_t               mc_cfg_q   [NUM_MC];

    // control register, written at any time
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prog_q <= PROG_RESET;
        end else if (reg_wr && ctrl_hit) begin
            prog_q <= reg_wdata[0];
        end
    end

    // and-array masks, one row of three words per term
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                and_mask_q[t] <= '0;
            end
        end else if (cfg_wr_ok && and_hit) begin
            and_mask_q[sel_term][sel_word*DATA_W +: DATA_W] <= reg_wdata;
        end
    end

    // steering slots, four words per macrocell
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int m = 0; m < NUM_MC; m++) begin
                steer_q[m] <= '0;
            end
        end else if (cfg_wr_ok && steer_hit) begin
            steer_q[sel_mc][sel_word*DATA_W +: DATA_W] <= reg_wdata;
        end
    end

    // per-macrocell configuration word
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int m = 0; m < NUM_MC; m++) begin
                mc_cfg_q[m] <= CFG_RESET;
            end
        end else if (cfg_wr_ok && cfg_hit) begin
            mc_cfg_q[sel_mc] <= cmb_cfg_t'(reg_wdata[CFG_W-1:0]);
        end
    end

    // ***************************************************
    // product term array
    // ***************************************************
    logic [NUM_LIT-1:0]     lit;
    logic [NUM_TERM-1:0]    pt;
    logic [NUM_TERM_P2-1:0] pt_pad;

    // literals only from the routing matrix
    // true and complement of every input
    for (genvar j = 0; j < NUM_ROUTE; j++) begin : g_lit
        assign lit[2*j]   = route_in[j];
        assign lit[2*j+1] = ~route_in[j];
    end

    // 86 and-terms over 72 literals
    // an empty mask gives a low term rather than a stuck-high one
    for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
        assign pt[t] = (|and_mask_q[t][NUM_LIT-1:0])
                       && ((and_mask_q[t][NUM_LIT-1:0] & ~lit) == '0);
    end

    // padding makes any out-of-range slot index read as low
    assign pt_pad = {{(NUM_TERM_P2-NUM_TERM){1'b0}}, pt};

    // ***************************************************
    // allocator and macrocells
    // ***************************************************
    logic [NUM_MC-1:0] mc_sum;
    logic [NUM_MC-1:0] mc_fb;
    logic [NUM_MC-1:0] mc_pin;

    for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
        logic [NUM_SLOT-1:0] hit;
        logic                nb_pin;

        // at most sixteen slots per macrocell
        // slots may name the same term
        for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
            cmb_slot_t slot;
            assign slot   = cmb_slot_t'(steer_q[m][s*SLOT_W +: SLOT_W]);
            assign hit[s] = slot.valid && pt_pad[slot.idx];
        end
        assign mc_sum[m] = |hit;

        // odd cells buried, their neighbour owns the pin
        assign nb_pin = pin_level_q[m/2];

        cmb_macrocell #(
            .IS_IO     ((m % 2) == 0)
        ) u_mc (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .sum       (mc_sum[m]),
            .cfg       (mc_cfg_q[m]),
            .gclk_rise (gclk_rise),
            .gclk_lvl  (gclk_s2_q),
            .pin_nb    (nb_pin),
            .fb_q      (mc_fb[m]),
            .pin_q     (mc_pin[m])
        );
    end

    assign route_fb_q = mc_fb;

    for (genvar i = 0; i < NUM_IO; i++) begin : g_io
        assign io_out[i] = mc_pin[2*i];
    end

    // ***************************************************
    // output enables and pin hold
    // ***************************************************
    logic [NUM_HOLD-1:0] own_drv;
    logic [NUM_HOLD-1:0] own_val;

    assign own_drv = {{NUM_DED{1'b0}}, io_oe_q};
    assign own_val = {{NUM_DED{1'b0}}, io_out};

    // pins are released while the block is being reprogrammed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            io_oe_q <= '0;
        end else begin
            for (int i = 0; i < NUM_IO; i++) begin
                io_oe_q[i] <= mc_cfg_q[2*i].oe_en && !prog_q;
            end
        end
    end

    // hold last driven level when undriven
    // the pin's own drive takes the output value, foreign drive the sampled pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_level_q <= '0;
        end else begin
            for (int i = 0; i < NUM_HOLD; i++) begin
                if (own_drv[i]) begin
                    pin_level_q[i] <= own_val[i];
                end else if (drv_s2_q[i]) begin
                    pin_level_q[i] <= pin_s2_q[i];
                end
            end
        end
    end

    // ***************************************************
    // read back
    // ***************************************************
    logic [DATA_W-1:0] rd_mux;

    // unmapped addresses read as zero
    assign rd_mux = ctrl_hit   ? {{(DATA_W-1){1'b0}}, prog_q} :
                    status_hit ? {{(DATA_W-NUM_MC){1'b0}}, mc_fb} :
                    cfg_hit    ? {{(DATA_W-CFG_W){1'b0}}, mc_cfg_q[sel_mc]} :
                    steer_hit  ? steer_q[sel_mc][sel_word*DATA_W +: DATA_W] :
                    and_hit    ? and_mask_q[sel_term][sel_word*DATA_W +: DATA_W] :
                                 {DATA_W{1'b0}};

    // read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

endmodule : cmb_block

//--- include/cmb_pkg.sv
// Contract
// - 36 routed inputs, both polarities, 86 terms
// - sixteen macrocells, every second has a pin
// - each macrocell sums zero to sixteen terms
// - one term may feed several macrocells
// - i/o macrocell may bypass its register
// - polarity inversion on the summed input
// - storage clocked by one of two clocks
// - i/o feedback path separate from pin
// - buried modes: comb, d, toggle, latch
// - buried clock choice same as i/o
// - buried input register captures neighbour pin
// - buried output always reaches routing matrix
// - all and-array literals come via routing matrix
// - weak hold keeps last pin level
package cmb_pkg;

    // ***************************************************
    // array and block sizes
    // ***************************************************
    localparam int NUM_ROUTE   = 36;
    localparam int NUM_LIT     = 2 * NUM_ROUTE;
    localparam int NUM_TERM    = 86;
    localparam int NUM_TERM_P2 = 128;
    localparam int NUM_MC      = 16;
    localparam int NUM_IO      = NUM_MC / 2;
    localparam int NUM_DED     = 1;
    localparam int NUM_HOLD    = NUM_IO + NUM_DED;
    localparam int NUM_SLOT    = 16;
    localparam int SLOT_W      = 8;
    localparam int TERM_IDX_W  = 7;
    localparam int NUM_GCLK    = 2;

    // ***************************************************
    // register port
    // ***************************************************
    localparam int ADDR_W      = 12;
    localparam int DATA_W      = 32;
    localparam int AND_ROW_W   = 96;
    localparam int STEER_ROW_W = NUM_SLOT * SLOT_W;
    localparam int AND_WORDS   = 3;

    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [5:0]  CFG_PAGE    = 6'h01;
    localparam logic [3:0]  STEER_PAGE  = 4'h4;
    localparam logic [0:0]  AND_PAGE    = 1'h1;

    // control register reset value
    localparam logic        PROG_RESET  = 1'h0;

    // ***************************************************
    // macrocell configuration
    // ***************************************************
    typedef enum logic [1:0] {
        CMB_MODE_COMB,
        CMB_MODE_DFF,
        CMB_MODE_TFF,
        CMB_MODE_LATCH
    } cmb_mode_t;

    typedef struct packed {
        logic      oe_en;
        logic      in_reg;
        logic      clk_sel;
        logic      invert;
        logic      bypass;
        cmb_mode_t mode;
    } cmb_cfg_t;

    localparam int CFG_W = $bits(cmb_cfg_t);
    localparam cmb_cfg_t CFG_RESET = '{oe_en: 1'h0, in_reg: 1'h0, clk_sel: 1'h0,
                                        invert: 1'h0, bypass: 1'h0, mode: CMB_MODE_COMB};

    // one steering slot: valid flag and term index
    typedef struct packed {
        logic                  valid;
        logic [TERM_IDX_W-1:0] idx;
    } cmb_slot_t;

endpackage : cmb_pkg

//--- src/cmb_macrocell.sv
`timescale 1ns/100ps
module cmb_macrocell
    import cmb_pkg::*;
#(
    parameter bit IS_IO = 1'b1
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // summed terms and configuration
    input  wire logic                sum,
    input  cmb_cfg_t                 cfg,
    // global clock events and levels
    input  wire logic [NUM_GCLK-1:0] gclk_rise,
    input  wire logic [NUM_GCLK-1:0] gclk_lvl,
    // neighbouring pin level, buried cells only
    input  wire logic                pin_nb,
    // outputs
    output logic                     fb_q,
    output logic                     pin_q
);

    // ***************************************************
    // data path
    // ***************************************************
    logic store_q;
    logic store_d;
    logic pol_sum;
    logic src;
    logic ce;
    logic lvl;
    logic out_val;

    assign pol_sum = sum ^ cfg.invert;
    assign ce      = gclk_rise[cfg.clk_sel];
    assign lvl     = gclk_lvl[cfg.clk_sel];
    assign src     = (!IS_IO && cfg.in_reg) ? pin_nb : pol_sum;

    // storage next value by mode
    always_comb begin
        store_d = store_q;
        if (IS_IO) begin
            if (ce) begin
                store_d = src;
            end
        end else begin
            case (cfg.mode)
                CMB_MODE_COMB:  store_d = ce ? src : store_q;
                CMB_MODE_DFF:   store_d = ce ? src : store_q;
                CMB_MODE_TFF:   store_d = ce ? (store_q ^ src) : store_q;
                CMB_MODE_LATCH: store_d = lvl ? src : store_q;
                default:        store_d = store_q;
            endcase
        end
    end

    // bypass gives combinatorial output
    // an input register in comb mode still acts as d-type
    assign out_val = IS_IO ? (cfg.bypass ? src : store_q)
                           : ((cfg.mode == CMB_MODE_COMB && !cfg.in_reg) ? src : store_q);

    // storage and output flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            store_q <= 1'b0;
            fb_q    <= 1'b0;
            pin_q   <= 1'b0;
        end else begin
            store_q <= store_d;
            fb_q    <= out_val;
            pin_q   <= IS_IO ? out_val : 1'b0;
        end
    end

endmodule : cmb_macrocell

//--- verification/cmb_block_properties.sv
`timescale 1ns/100ps
module cmb_block_properties
    import cmb_pkg::*;
(
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst_b,
    // register port
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [DATA_W-1:0]    reg_rdata_q,
    // routing side and pins
    input wire logic [NUM_ROUTE-1:0] route_in,
    input wire logic [NUM_MC-1:0]    route_fb_q,
    input wire logic [NUM_HOLD-1:0]  pin_level_q,
    input wire logic [NUM_GCLK-1:0]  gclk_pin,
    input wire logic [NUM_IO-1:0]    io_in,
    input wire logic [NUM_IO-1:0]    io_ext_drv,
    input wire logic [NUM_IO-1:0]    io_out,
    input wire logic [NUM_IO-1:0]    io_oe_q,
    input wire logic [NUM_DED-1:0]   ded_ext_drv
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_prog_set;
        reg_wr && reg_addr == CTRL_ADDR && reg_wdata[0];
    endsequence
    // six cycles cover the deepest path: sync plus clock event plus feedback
    sequence s_quiet;
        ($stable(route_in) && $stable(gclk_pin) && $stable(io_in) && $stable(io_ext_drv) && !reg_wr) [*6];
    endsequence
    property p_rd_idle;
        !reg_rd |=> reg_rdata_q == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_status;
        reg_rd && reg_addr == STATUS_ADDR |=> reg_rdata_q[15:0] == $past(route_fb_q);
    endproperty
    a_status: assert property (p_status) else $error("status differs from feedback");
    property p_prog_release;
        s_prog_set |=> ##1 io_oe_q == '0;
    endproperty
    a_prog_release: assert property (p_prog_release) else $error("pins driven in prog mode");
    property p_oe_cause;
        io_oe_q != $past(io_oe_q) |-> $past(reg_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
    property p_pin_drive;
        |io_oe_q |=> ((pin_level_q[NUM_IO-1:0] ^ $past(io_out)) & $past(io_oe_q)) == '0;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("driven pin level lost");
    property p_pin_hold;
        (!io_oe_q[0] && !io_ext_drv[0]) [*4] |=> $stable(pin_level_q[0]);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("floating pin not held");
    property p_ded_hold;
        !ded_ext_drv[0] [*4] |=> $stable(pin_level_q[NUM_IO]);
    endproperty
    a_ded_hold: assert property (p_ded_hold) else $error("floating input not held");
    property p_quiet;
        s_quiet |-> $stable(route_fb_q);
    endproperty
    a_quiet: assert property (p_quiet) else $error("feedback moved with inputs still");
endmodule : cmb_block_properties

bind cmb_block cmb_block_properties u_cmb_block_properties (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_q, .route_in, .route_fb_q, .pin_level_q, .gclk_pin, .io_in,
    .io_ext_drv, .io_out, .io_oe_q, .ded_ext_drv);

//--- verification/cmb_pins_model.sv
`timescale 1ns/100ps
module cmb_pins_model
    import cmb_pkg::*;
(
    // clock
    input  wire logic              clk_sys,
    // block side of the pins
    input  wire logic [NUM_IO-1:0] io_out,
    input  wire logic [NUM_IO-1:0] io_oe_q,
    // outside drivers
    input  wire logic [NUM_IO-1:0] ext_en,
    input  wire logic [NUM_IO-1:0] ext_val,
    // levels seen by the block
    output logic      [NUM_IO-1:0] io_in,
    output logic      [NUM_IO-1:0] io_ext_drv
);
    // ********
    // pin wires
    // ********
    logic [NUM_IO-1:0] last_q = '0;
    // pins reach block
    // a floating pin flips every cycle, so only the block's hold keeps a value
    assign io_in = (io_oe_q & io_out) | (~io_oe_q & ext_en & ext_val) | (~io_oe_q & ~ext_en & ~last_q);
    assign io_ext_drv = ext_en;
    always_ff @(posedge clk_sys) begin
        last_q <= io_in;
    end
endmodule : cmb_pins_model

//--- verification/cmb_block_tb.sv
`timescale 1ns/100ps
module cmb_block_tb
    import cmb_pkg::*;
;
    // ********
    // bench
    // ********
    logic                 clk_sys = 1'b0;
    logic                 rst_b = 1'b0;
    logic [ADDR_W-1:0]    reg_addr = '0;
    logic [DATA_W-1:0]    reg_wdata = '0;
    logic [DATA_W-1:0]    reg_rdata_q, rd_v;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [NUM_ROUTE-1:0] route_in = '0;
    logic [NUM_MC-1:0]    route_fb_q;
    logic [NUM_HOLD-1:0]  pin_level_q;
    logic [NUM_GCLK-1:0]  gclk_pin = '0;
    logic [NUM_IO-1:0]    io_in, io_ext_drv, io_out, io_oe_q;
    logic [NUM_IO-1:0]    ext_en = '0;
    logic [NUM_IO-1:0]    ext_val = '0;
    logic [NUM_DED-1:0]   ded_in = '0;
    logic [NUM_DED-1:0]   ded_ext_drv = '0;
    int                   n_fail = 0;
    int                   tests_run = 0;

    cmb_block u_cmb_block (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .route_in, .route_fb_q, .pin_level_q, .gclk_pin, .io_in, .io_ext_drv, .io_out, .io_oe_q,
        .ded_in, .ded_ext_drv);
    cmb_pins_model u_cmb_pins_model (.clk_sys, .io_out, .io_oe_q, .ext_en, .ext_val, .io_in, .io_ext_drv);

    // 50 MHz system clock
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd_v = reg_rdata_q;
    endtask : rd

    // held long enough for the three-edge synchroniser
    task automatic pulse(input int k);
        @(posedge clk_sys) gclk_pin[k] <= 1'b1;
        cyc(4);
        @(posedge clk_sys) gclk_pin[k] <= 1'b0;
        cyc(6);
    endtask : pulse

    // terms 0,1,2,85 and six configured macrocells
    task automatic sc_program;
        wr(CTRL_ADDR, 32'h1);
        wr(12'h800, 32'h1);
        wr(12'h810, 32'h8);
        wr(12'h828, 32'h80);
        wr(12'hd50, 32'h50);
        wr(12'h400, 32'hd5);
        wr(12'h410, 32'h80);
        wr(12'h41c, 32'h81000000);
        wr(12'h430, 32'h80);
        wr(12'h450, 32'h82);
        wr(12'h040, 32'h44);
        wr(12'h04c, 32'h08);
        wr(12'h054, 32'h11);
        wr(12'h05c, 32'h0a);
        wr(12'h064, 32'h21);
        wr(CTRL_ADDR, 32'h0);
        rd(12'h828);
        check(rd_v, 32'h80);
    endtask : sc_program

    // every input pattern through shared, inverted and bypassed sums
    task automatic sc_comb;
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            @(posedge clk_sys) route_in <= {v[0], 31'h0, v};
            cyc(3);
            check({route_fb_q[3], route_fb_q[1], route_fb_q[0], io_out[0], pin_level_q[0]},
                {~v[0], v[0] | ~v[1], {3{v[3] & v[2]}}});
        end
        check(io_oe_q, 8'h01);
    endtask : sc_comb

    // clock choice, d, toggle and input register
    task automatic sc_clock;
        @(posedge clk_sys) route_in <= '0;
        ext_en[4] <= 1'b1;
        ext_val[4] <= 1'b1;
        pulse(1);
        check({route_fb_q[9], route_fb_q[7], route_fb_q[5]}, 3'h1);
        @(posedge clk_sys) route_in[35] <= 1'b1;
        pulse(0);
        check({route_fb_q[9], route_fb_q[7], route_fb_q[5]}, 3'h7);
        @(posedge clk_sys) ext_val[4] <= 1'b0;
        cyc(4);
        pulse(0);
        check({route_fb_q[9], route_fb_q[7], route_fb_q[5]}, 3'h1);
    endtask : sc_clock

    // released pins keep their last driven level
    task automatic sc_hold;
        @(posedge clk_sys) ext_en[1] <= 1'b1;
        ext_val[1] <= 1'b1;
        ded_in <= 1'b1;
        ded_ext_drv <= 1'b1;
        cyc(6);
        check({pin_level_q[8], pin_level_q[1]}, 2'h3);
        @(posedge clk_sys) ext_en[1] <= 1'b0;
        ded_in <= 1'b0;
        ded_ext_drv <= 1'b0;
        cyc(8);
        check({pin_level_q[8], pin_level_q[1]}, 2'h3);
    endtask : sc_hold

    // config writes refused outside prog mode
    task automatic sc_refuse;
        // input 0 high: a steering write that slipped through would lift fb3
        @(posedge clk_sys) route_in <= 36'h1;
        wr(12'h040, 32'h0);
        wr(12'h430, 32'h0);
        cyc(3);
        check({io_oe_q[0], route_fb_q[3]}, 2'h2);
        rd(STATUS_ADDR);
        check(rd_v, 32'h22);
        rd(12'hffc);
        check(rd_v, 32'h0);
        wr(CTRL_ADDR, 32'h1);
        // enable falls one edge after the prog bit, look one edge later
        cyc(2);
        check(io_oe_q, 8'h00);
        wr(CTRL_ADDR, 32'h0);
    endtask : sc_refuse

    // latch follows its sum only while clock 0 is high
    task automatic sc_latch;
        wr(CTRL_ADDR, 32'h1);
        wr(12'h06c, 32'h03);
        wr(12'h4b0, 32'h80);
        wr(CTRL_ADDR, 32'h0);
        @(posedge clk_sys) route_in <= 36'h1;
        cyc(4);
        check(route_fb_q[11], 1'b0);
        @(posedge clk_sys) gclk_pin[0] <= 1'b1;
        cyc(5);
        check(route_fb_q[11], 1'b1);
        @(posedge clk_sys) route_in <= '0;
        cyc(3);
        check(route_fb_q[11], 1'b0);
        @(posedge clk_sys) gclk_pin[0] <= 1'b0;
        cyc(4);
        @(posedge clk_sys) route_in <= 36'h1;
        cyc(3);
        check(route_fb_q[11], 1'b0);
    endtask : sc_latch

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    initial begin
        cyc(8);
        rst_b <= 1'b1;
        sc_program;
        sc_comb;
        sc_clock;
        sc_hold;
        sc_refuse;
        sc_latch;
        give_verdict;
    end

    // watchdog against a hung run
    initial begin
        cyc(20000);
        n_fail++;
        give_verdict;
    end
endmodule : cmb_block_tb
